// File: verilog/frcs_pkg.sv
// Constants, types and timing for the filter reset and calibration scaling block
// Assumes a 10 MHz system clock and a modulator clock enable derived from it
package frcs_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam int SYNC_DELAY_CLK = 4;
  localparam int REG_RST_MOD = 32;
  localparam int START_RST_MOD = 32;
  localparam int MOD_DIV = 16;
  localparam int DATA_W = 24;
  localparam int PROD_W = 50;
  localparam int GAIN_SHIFT = 22;
  localparam int RATE_W = 4;
  localparam int CNT_W = 20;
  localparam int PGA_W = 3;
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [23:0] GAIN_UNITY = 24'h400000;
  localparam logic [23:0] CODE_MAX = 24'h7FFFFF;
  localparam logic [23:0] CODE_MIN = 24'h800000;
  localparam logic [1:0] OFC_IDX_LO = 2'h0;
  localparam logic [1:0] OFC_IDX_MID = 2'h1;
  localparam logic [1:0] OFC_IDX_HI = 2'h2;

  // Per-rate cycle counts, index 0 is 5 SPS, index 9 is 2000 SPS
  localparam logic [19:0] FIRST_SYNC [10] = '{20'd816160, 20'd408096, 20'd204064, 20'd102072,
    20'd51064, 20'd25560, 20'd12796, 20'd6428, 20'd4156, 20'd2108};
  localparam logic [19:0] FIRST_FULL [10] = '{20'd820265, 20'd412201, 20'd208169, 20'd103106,
    20'd52098, 20'd26594, 20'd13314, 20'd6946, 20'd4674, 20'd2370};
  localparam logic [19:0] STEADY [10] = '{20'd816128, 20'd408064, 20'd204032, 20'd102016,
    20'd51008, 20'd25504, 20'd12736, 20'd6368, 20'd4096, 20'd2048};

  typedef enum logic [1:0] {FRCS_SRC_NONE, FRCS_SRC_SYNC, FRCS_SRC_FULL} frcs_src_e;

  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } frcs_sample_s;

  typedef struct packed {
    logic wr;
    logic [1:0] idx;
    logic [7:0] data;
  } frcs_byte_wr_s;
endpackage

// File: verilog/frcs_scale.sv
// Offset subtract, gain multiply and 24-bit clipping of one filter sample
// Assumes inputs on the system clock; result registered one cycle later
`timescale 1ns/100ps
module frcs_scale (
  input wire logic clk,
  input wire logic rst,
  input frcs_pkg::frcs_sample_s raw,
  input wire logic [23:0] offset,
  input wire logic [23:0] gain,
  output frcs_pkg::frcs_sample_s scaled
);
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [27:0] shifted;
  frcs_pkg::frcs_sample_s next_scaled;

  always_comb begin
    diff = $signed({raw.data[23], raw.data}) - $signed({offset[23], offset});
    prod = $signed({{25{diff[24]}}, diff}) * $signed({26'h0000000, gain});
    shifted = 28'(prod >>> frcs_pkg::GAIN_SHIFT);
    next_scaled.valid = raw.valid;
    if (shifted > $signed({{4{1'b0}}, frcs_pkg::CODE_MAX})) begin
      next_scaled.data = frcs_pkg::CODE_MAX;
    end else if (shifted < $signed({{4{1'b1}}, frcs_pkg::CODE_MIN})) begin
      next_scaled.data = frcs_pkg::CODE_MIN;
    end else begin
      next_scaled.data = shifted[23:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scaled <= '0;
    end else begin
      scaled <= next_scaled;
    end
  end
endmodule // frcs_scale

// File: verilog/frcs_top.sv
// Filter reset control, conversion timing and calibration scaling
// Assumes strobes from the serial decoder are one-cycle pulses on clk; start pin is asynchronous
// Summary of operation
// - Reset filter on config and channel writes, resync, start, reset
// - Resync resets filter four clocks later
// - Channel select write always resets filter
// - Config writes hold reset 32 modulator clocks
// - Overlapping reset pulses combine into one
// - Resync or channel write gives short first conversion unless a config or start reset is still counting
// - Other resets give long first conversion
// - Later conversions use steady per-rate count
// - Subtract offset then scale by gain
// - Clip result to 24-bit code range
// - Corrections loadable by host or calibration
// - Offset is 24-bit two's complement, three bytes
// - Offset zero applies no correction
// - Start rise holds filter reset 32 modulator clocks
// - Gain code 400000h is unity
// - Gain change reloads trimmed gain value
`timescale 1ns/100ps
module frcs_top #(
  parameter int MOD_DIV = frcs_pkg::MOD_DIV,
  parameter logic [23:0] GAIN_TRIM [8] = '{default: frcs_pkg::GAIN_UNITY}
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_cmd,
  input wire logic resync_cmd,
  input wire logic wake_cmd,
  input wire logic start_pin,
  input wire logic chan_wr_done,
  input wire logic cfg_wr_done,
  input wire logic [3:0] rate_sel,
  input wire logic [2:0] pga_gain,
  input frcs_pkg::frcs_byte_wr_s ofc_wr,
  input frcs_pkg::frcs_byte_wr_s fsc_wr,
  input wire logic cal_ofc_load,
  input wire logic cal_fsc_load,
  input wire logic [23:0] cal_value,
  input frcs_pkg::frcs_sample_s filt_in,
  output logic filter_rst_n,
  output logic conv_done,
  output logic [23:0] offset_correction_word,
  output logic [23:0] gain_correction,
  output frcs_pkg::frcs_sample_s code_out
);
  function automatic logic [23:0] put_byte(input logic [23:0] w, input frcs_pkg::frcs_byte_wr_s b);
    logic [23:0] r;
    r = w;
    case (b.idx)
      frcs_pkg::OFC_IDX_LO: r[7:0] = b.data;
      frcs_pkg::OFC_IDX_MID: r[15:8] = b.data;
      frcs_pkg::OFC_IDX_HI: r[23:16] = b.data;
      default: r = w;
    endcase
    return r;
  endfunction

  logic start_s1, start_s2, start_d;
  logic [4:0] mod_div_cnt, next_mod_div_cnt;
  logic mod_tick;
  logic [2:0] sync_dly, next_sync_dly;
  logic [5:0] cfg_cnt, next_cfg_cnt;
  logic [5:0] start_cnt, next_start_cnt;
  logic [2:0] pga_q;
  logic [19:0] conv_cnt, next_conv_cnt;
  logic first_conv, next_first_conv;
  frcs_pkg::frcs_src_e pend_src, next_pend_src;
  logic next_filter_rst_n, next_conv_done;
  logic [23:0] next_ofc, next_fsc;
  logic start_rise, sync_fire, rst_now;
  logic [3:0] rate_idx;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_s1 <= 1'b1;
      start_s2 <= 1'b1;
      start_d <= 1'b1;
    end else begin
      start_s1 <= start_pin;
      start_s2 <= start_s1;
      start_d <= start_s2;
    end
  end

  always_comb begin
    start_rise = start_s2 && !start_d;
    mod_tick = (mod_div_cnt == 5'(MOD_DIV - 1));
    next_mod_div_cnt = mod_tick ? 5'h00 : mod_div_cnt + 5'h01;
    rate_idx = (rate_sel > 4'h9) ? 4'h9 : rate_sel;
    // Resync delay
    sync_fire = (sync_dly == 3'h1);
    next_sync_dly = sync_dly;
    if (resync_cmd) begin
      next_sync_dly = 3'(frcs_pkg::SYNC_DELAY_CLK);
    end else if (sync_dly != 3'h0) begin
      next_sync_dly = sync_dly - 3'h1;
    end
    // Config write pulse of 32 modulator clocks
    next_cfg_cnt = cfg_cnt;
    if (cfg_wr_done) begin
      next_cfg_cnt = 6'(frcs_pkg::REG_RST_MOD);
    end else if (mod_tick && cfg_cnt != 6'h00) begin
      next_cfg_cnt = cfg_cnt - 6'h01;
    end
    next_start_cnt = start_cnt;
    if (start_rise) begin
      next_start_cnt = 6'(frcs_pkg::START_RST_MOD);
    end else if (mod_tick && start_cnt != 6'h00) begin
      next_start_cnt = start_cnt - 6'h01;
    end
    // Low while any source asserts: AND of active-low pulses
    rst_now = reset_cmd || sync_fire || chan_wr_done || (next_cfg_cnt != 6'h00)
      || (next_start_cnt != 6'h00);
    next_filter_rst_n = !rst_now;
    next_pend_src = pend_src;
    if (reset_cmd || cfg_wr_done || start_rise || wake_cmd) begin
      next_pend_src = frcs_pkg::FRCS_SRC_FULL;
    end else if ((sync_fire || chan_wr_done) && cfg_cnt == 6'h00 && start_cnt == 6'h00) begin
      next_pend_src = frcs_pkg::FRCS_SRC_SYNC;
    end
    next_conv_done = 1'b0;
    next_first_conv = first_conv;
    next_conv_cnt = conv_cnt;
    if (rst_now || wake_cmd) begin
      next_conv_cnt = 20'h00000;
      next_first_conv = 1'b1;
    end else begin
      if (pend_src == frcs_pkg::FRCS_SRC_FULL) begin
        next_conv_done = first_conv && (conv_cnt == frcs_pkg::FIRST_FULL[rate_idx] - 20'h00001);
      end else if (pend_src == frcs_pkg::FRCS_SRC_SYNC) begin
        next_conv_done = first_conv && (conv_cnt == frcs_pkg::FIRST_SYNC[rate_idx] - 20'h00001);
      end
      if (!first_conv) begin
        next_conv_done = (conv_cnt == frcs_pkg::STEADY[rate_idx] - 20'h00001);
      end
      next_conv_cnt = next_conv_done ? 20'h00000 : conv_cnt + 20'h00001;
      if (next_conv_done) begin
        next_first_conv = 1'b0;
      end
    end
    // Correction registers
    next_ofc = offset_correction_word;
    if (cal_ofc_load) begin
      next_ofc = cal_value;
    end else if (ofc_wr.wr) begin
      next_ofc = put_byte(offset_correction_word, ofc_wr);
    end
    next_fsc = gain_correction;
    if (pga_gain != pga_q) begin
      next_fsc = GAIN_TRIM[pga_gain];
    end else if (cal_fsc_load) begin
      next_fsc = cal_value;
    end else if (fsc_wr.wr) begin
      next_fsc = put_byte(gain_correction, fsc_wr);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mod_div_cnt <= 5'h00;
      sync_dly <= 3'h0;
      cfg_cnt <= 6'h00;
      start_cnt <= 6'h00;
      pend_src <= frcs_pkg::FRCS_SRC_FULL;
      filter_rst_n <= 1'b0;
      conv_cnt <= 20'h00000;
      first_conv <= 1'b1;
      conv_done <= 1'b0;
      offset_correction_word <= frcs_pkg::OFFSET_RESET;
      gain_correction <= frcs_pkg::GAIN_UNITY;
      pga_q <= 3'h0;
    end else begin
      mod_div_cnt <= next_mod_div_cnt;
      sync_dly <= next_sync_dly;
      cfg_cnt <= next_cfg_cnt;
      start_cnt <= next_start_cnt;
      pend_src <= next_pend_src;
      filter_rst_n <= next_filter_rst_n;
      conv_cnt <= next_conv_cnt;
      first_conv <= next_first_conv;
      conv_done <= next_conv_done;
      offset_correction_word <= next_ofc;
      gain_correction <= next_fsc;
      pga_q <= pga_gain;
    end
  end

  frcs_scale frcs_scale_inst (
    .clk(clk),
    .rst(rst),
    .raw(filt_in),
    .offset(offset_correction_word),
    .gain(gain_correction),
    .scaled(code_out)
  );
endmodule // frcs_top

// File: tb/frcs_props.sv
// Checker for frcs_top reset timing and scaling
// Bound to frcs_top below
`timescale 1ns/100ps
module frcs_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic resync_cmd,
  input wire logic start_pin,
  input wire logic chan_wr_done,
  input wire logic cfg_wr_done,
  input wire logic [2:0] pga_gain,
  input frcs_pkg::frcs_byte_wr_s ofc_wr,
  input wire logic cal_ofc_load,
  input wire logic [23:0] cal_value,
  input frcs_pkg::frcs_sample_s filt_in,
  input wire logic filter_rst_n,
  input wire logic conv_done,
  input wire logic [23:0] offset_correction_word,
  input wire logic [23:0] gain_correction,
  input frcs_pkg::frcs_sample_s code_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_resync_delay: assert property (resync_cmd |-> ##[4:5] !filter_rst_n) else $error("resync late");
  a_chan_reset: assert property (chan_wr_done |=> !filter_rst_n) else $error("chan reset");
  a_cfg_hold: assert property (cfg_wr_done |=> !filter_rst_n [*8]) else $error("cfg short");
  a_start_hold: assert property ($rose(start_pin) |-> ##3 !filter_rst_n [*8]) else $error("start short");
  a_reset_quiet: assert property (!filter_rst_n |=> !conv_done) else $error("done in reset");
  a_done_pulse: assert property (conv_done |=> !conv_done) else $error("done long");
  a_code_valid: assert property (filt_in.valid |=> code_out.valid) else $error("no code");
  a_cal_offset: assert property (cal_ofc_load |=> offset_correction_word == $past(cal_value)) else $error("cal");
  a_offset_hold: assert property (!ofc_wr.wr && !cal_ofc_load |=> $stable(offset_correction_word)) else $error("ofs");
  a_pga_reload: assert property ($changed(pga_gain) |=> gain_correction == 24'h400000) else $error("trim");
  c_cfg: cover property (cfg_wr_done);
  c_resync: cover property (resync_cmd);
  c_clip: cover property (code_out.valid && code_out.data == 24'h7FFFFF);
endmodule // frcs_props
bind frcs_top frcs_props frcs_props_inst (.*);

// File: tb/frcs_host.sv
// Host model: one-cycle command and write strobes
// Assumes the block samples strobes on rising clk
`timescale 1ns/100ps
module frcs_host (
  input wire logic clk,
  output logic reset_cmd,
  output logic wake_cmd,
  output logic cfg_wr_done,
  output logic chan_wr_done,
  output logic resync_cmd
);
  initial {reset_cmd, wake_cmd, cfg_wr_done, chan_wr_done, resync_cmd} = 5'h00;
  // Kind 0 resync, 1 channel, 2 config, 3 wake, 4 reset
  task automatic send(input int kind);
    {reset_cmd, wake_cmd, cfg_wr_done, chan_wr_done, resync_cmd} = 5'(1 << kind);
    @(posedge clk);
    #1;
    {reset_cmd, wake_cmd, cfg_wr_done, chan_wr_done, resync_cmd} = 5'h00;
  endtask
endmodule // frcs_host

// File: tb/test_frcs_top.sv
// Bench for frcs_top: reset timing, conversion lengths, scaling
// Assumes the host model drives strobes; rate index 9
`timescale 1ns/100ps
module test_frcs_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start_pin = 1'b1;
  logic [3:0] rate_sel = 4'h9;
  logic [2:0] pga_gain = 3'h0;
  logic cal_ofc_load = 1'b0;
  logic cal_fsc_load = 1'b0;
  logic [23:0] cal_value = 24'h000000;
  frcs_pkg::frcs_byte_wr_s ofc_wr = '0;
  frcs_pkg::frcs_byte_wr_s fsc_wr = '0;
  frcs_pkg::frcs_sample_s filt_in = '0;
  frcs_pkg::frcs_sample_s code_out;
  logic reset_cmd, resync_cmd, wake_cmd, chan_wr_done, cfg_wr_done, filter_rst_n, conv_done;
  logic [23:0] offset_correction_word, gain_correction;
  int fail_count = 0;
  int n_tests = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  frcs_host frcs_host_inst (.*);
  frcs_top frcs_top_inst (.*);
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Cycles from last low reset sample to conv_done, plus low samples seen
  task automatic conv_len(output int n, output int lo);
    n = 0;
    lo = 0;
    for (int i = 0; i < 4000; i++) begin
      step;
      n = (filter_rst_n === 1'b0) ? 0 : n + 1;
      lo += (filter_rst_n === 1'b0);
      if (conv_done === 1'b1) break;
    end
  endtask
  task automatic wr_word(input logic ofs, input logic [23:0] v);
    for (int i = 0; i < 3; i++) begin
      if (ofs) ofc_wr = '{1'b1, 2'(i), v[8*i +: 8]};
      else fsc_wr = '{1'b1, 2'(i), v[8*i +: 8]};
      step;
    end
    ofc_wr = '0;
    fsc_wr = '0;
  endtask
  task automatic t_scale(input logic [23:0] ofs, input logic [23:0] gain, input logic [23:0] din);
    logic signed [49:0] p;
    logic [23:0] exp;
    wr_word(1'b1, ofs);
    wr_word(1'b0, gain);
    chk("offset word", ofs, offset_correction_word);
    filt_in = '{1'b1, din};
    step;
    filt_in = '0;
    p = (($signed({din[23], din}) - $signed({ofs[23], ofs})) * $signed({1'b0, gain})) >>> 22;
    exp = (p > 50'sh7FFFFF) ? 24'h7FFFFF : (p < -50'sh800000) ? 24'h800000 : p[23:0];
    chk("scaled code", exp, code_out.data);
    $display("scale test done");
  endtask
  task automatic t_cal;
    cal_value = 24'h123456;
    cal_ofc_load = 1'b1;
    cal_fsc_load = 1'b1;
    step;
    cal_ofc_load = 1'b0;
    cal_fsc_load = 1'b0;
    chk("cal offset", 24'h123456, offset_correction_word);
    chk("cal gain", 24'h123456, gain_correction);
    pga_gain = 3'h5;
    step;
    chk("trim gain", 24'h400000, gain_correction);
    $display("calibration test done");
  endtask
  task automatic t_conv(input int kind, input int first, input int lo_min, input int lo_max);
    int n;
    int lo;
    if (kind == 5) begin
      start_pin = 1'b0;
      repeat (4) step;
      start_pin = 1'b1;
    end else begin
      frcs_host_inst.send(kind);
    end
    if (kind == 2) begin
      step;
      frcs_host_inst.send(1);
    end
    conv_len(n, lo);
    chk("first conversion", 24'(first), 24'(n));
    n_tests++;
    if (lo < lo_min || lo > lo_max) begin
      fail_count++;
      $display("[ERR] reset low cycles expected %0d..%0d seen %0d", lo_min, lo_max, lo);
    end
    if (kind == 0) begin
      conv_len(n, lo);
      chk("steady conversion", 24'h000800, 24'(n));
    end
    $display("conversion test %0d done", kind);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    step;
    t_scale(24'h000000, 24'h400000, 24'h000123);
    t_scale(24'h000001, 24'h400000, 24'h000000);
    t_scale(24'h7FFFFF, 24'h400000, 24'h800000);
    t_scale(24'h000000, 24'h800000, 24'h7FFFFF);
    t_scale(24'h000010, 24'h200000, 24'h000030);
    t_cal;
    t_conv(0, 2108, 1, 1);
    t_conv(1, 2108, 0, 1);
    t_conv(3, 2370, 0, 1);
    t_conv(2, 2370, 490, 512);
    t_conv(4, 2370, 0, 0);
    t_conv(5, 2370, 497, 512);
    final_report;
  end
  initial begin
    #3000000;
    fail_count++;
    final_report;
  end
endmodule // test_frcs_top
